// *** fmc_pkg.sv ***
package fmc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CFG_TWO       = 8'h02;
  localparam logic [7:0] ADDR_CFG_THREE     = 8'h03;
  localparam logic [7:0] ADDR_TACH_ENABLE   = 8'h07;
  localparam logic [7:0] ADDR_TACH_CONFIG   = 8'h08;
  localparam logic [7:0] ADDR_PIN_CFG_ONE   = 8'h09;
  localparam logic [7:0] ADDR_PIN_CFG_TWO   = 8'h0A;

  // reset values
  localparam logic [7:0] RST_CFG_TWO        = 8'h80;
  localparam logic [7:0] RST_CFG_THREE      = 8'h00;
  localparam logic [7:0] RST_TACH_ENABLE    = 8'h00;
  localparam logic [7:0] RST_TACH_CONFIG    = 8'h0F;
  localparam logic [7:0] RST_PIN_CFG_ONE    = 8'h00;
  localparam logic [7:0] RST_PIN_CFG_TWO    = 8'h00;
  localparam logic [7:0] RD_UNMAPPED        = 8'h00;

  // config two fields
  localparam int CFG2_FAST_BIT        = 0;
  localparam int CFG2_HIGH_FREQ_BIT   = 2;
  localparam int CFG2_HOT_ONE_DIS_BIT = 3;
  localparam int CFG2_HOT_TWO_DIS_BIT = 4;
  localparam int CFG2_FULL_SPEED_BIT  = 5;
  localparam int CFG2_PULSES_LSB      = 6;

  // config three fields
  localparam int CFG3_PIN_EN_BIT      = 0;
  localparam int CFG3_SCL_TMO_BIT     = 1;
  localparam int CFG3_SDA_TMO_BIT     = 2;
  localparam int CFG3_VID_THR_BIT     = 3;
  localparam int CFG3_THERM_THR_BIT   = 4;
  localparam int CFG3_INTR_CLR_BIT    = 5;
  localparam int CFG3_XOR_TREE_BIT    = 6;
  localparam int CFG3_CORE_LOW_BIT    = 7;

  // writable bits of the tach configuration
  localparam logic [7:0] TACH_CFG_WMASK = 8'h0F;
  // the intrusion clear bit never stores
  localparam logic [7:0] CFG3_WMASK     = 8'hDF;

  localparam int NUM_TACH = 8;
  localparam int NUM_PINS = 8;
  localparam int NUM_PAIRS = 4;

  // measurement rate
  localparam int CLK_FREQ_HZ        = 40_000_000;
  localparam int SLOW_MEAS_MS       = 1000;
  localparam int FAST_MEAS_MS       = 250;
  localparam int SLOW_MEAS_CYCLES   = (CLK_FREQ_HZ / 1000) * SLOW_MEAS_MS;
  localparam int FAST_MEAS_CYCLES   = (CLK_FREQ_HZ / 1000) * FAST_MEAS_MS;
  localparam int CNT_W              = 26;

endpackage

// *** fmc_rate_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface fmc_rate_if;
  logic fast;
  logic low_freq;
  logic tick;
  modport ctl   (output fast, output low_freq, input tick);
  modport timer (input fast, input low_freq, output tick);
endinterface
`default_nettype wire

// *** fmc_rate_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module fmc_rate_timer
  import fmc_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_MEAS_CYCLES,
  parameter int FAST_CYCLES = FAST_MEAS_CYCLES
) (
  input  wire logic i_clk,   // core clock
  input  wire logic i_nrst,  // sync reset, active low
  fmc_rate_if.timer rate     // rate select in, tick out
);

  localparam logic [CNT_W-1:0] SLOW_RELOAD = CNT_W'(SLOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] FAST_RELOAD = CNT_W'(FAST_CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } fmc_timer_s;

  fmc_timer_s r;
  fmc_timer_s next_r;

  assign rate.tick = r.tick;

  // a rate change takes effect at the next reload, not mid-period
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (!rate.low_freq) begin
      next_r.cnt = '0;
    end else if (r.cnt == '0) begin
      next_r.tick = 1'b1;
      next_r.cnt  = rate.fast ? FAST_RELOAD : SLOW_RELOAD;
    end else begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  property p_no_tick_high_freq;
    @(posedge i_clk) disable iff (!i_nrst)
      !rate.low_freq |=> !rate.tick;
  endproperty
  a_no_tick_high_freq: assert property (p_no_tick_high_freq)
    else $error("measurement tick outside low frequency mode");

  property p_tick_reload;
    @(posedge i_clk) disable iff (!i_nrst)
      (rate.low_freq && r.cnt == '0) |=>
        rate.tick && r.cnt == ($past(rate.fast) ? FAST_RELOAD : SLOW_RELOAD);
  endproperty
  a_tick_reload: assert property (p_tick_reload)
    else $error("measurement period reload wrong");

endmodule
`default_nettype wire

// *** fmc_config_regs.sv ***
// Behaviour
// - low frequency mode measures speed once a second, four times when fast set
// - config two bit 2 picks low frequency or fixed high frequency PWM
// - first regulator hot input forces full speed unless its disable bit set
// - second regulator hot input forces full speed unless its disable bit set
// - config two bit 5 forces every fan to full speed, resets low
// - bits 7:6 give pulses counted after second rising edge, x equals field plus one
// - all six registers lockable, soft resettable, defaults 0x80, 0x0F, else 0x00
// - once locked, lockable registers ignore writes until power cycle
// - soft reset restores unlocked registers, locked ones keep contents
// - config three bit 0 enables the general purpose pins
// - config three bits 1 and 2 enable clock and data line timeouts
// - writing one to config three bit 5 clears intrusion latch, self clearing
// - config three bit 6 selects XOR tree test mode
// - config three bit 7 enables the core rail low function
// - tach enable bit n enables speed measurement on tach input n+1
// - tach config bits 0..3 select continuous measurement on pairs 1/5..4/8
// - continuous pairs get no pulse stretching and no PWM synchronisation
// - tach config bits 7:4 are reserved, read only
// - pin config one even bits set polarity of pins 1..4
// - pin config one odd bits set direction of pins 1..4
// - pin config two holds same layout for pins 5..8, resets 0x00
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fmc_config_regs
  import fmc_pkg::*;
#(
  parameter int SLOW_CYCLES = SLOW_MEAS_CYCLES,
  parameter int FAST_CYCLES = FAST_MEAS_CYCLES
) (
  input  wire logic       I_MCLK,                 // core clock, 40 MHz
  input  wire logic       I_NRST,                 // power-on reset, sync, active low
  input  wire logic [7:0] I_ADDR,                 // register address
  input  wire logic [7:0] I_WDATA,                // write data
  input  wire logic       I_WR,                   // write strobe
  input  wire logic       I_RD,                   // read strobe
  output logic      [7:0] O_RDATA,                // read data, cycle after read
  input  wire logic       I_LOCK,                 // lock request level
  input  wire logic       I_SOFT_RESET,           // software reset pulse
  input  wire logic       I_REG_HOT_ONE,          // regulator_hot_input_one pin
  input  wire logic       I_REG_HOT_TWO,          // regulator_hot_input_two pin
  output logic            O_FULL_SPEED,           // all fans to full speed
  output logic            O_HIGH_FREQ_PWM,        // fixed high frequency PWM
  output logic            O_FAST_RATE,            // four measurements a second
  output logic            O_SPEED_MEAS_TICK,      // start of a measurement period
  output logic      [2:0] O_SPEED_PULSE_COUNT,    // speed_pulse_count, 1..4
  output logic      [7:0] O_SPEED_MEAS_EN,        // per tach input measure enable
  output logic      [3:0] O_CONTINUOUS_PAIR,      // continuous_speed_pair bits
  output logic      [7:0] O_PULSE_STRETCH_EN,     // per tach input pulse stretch
  output logic      [7:0] O_TACH_SYNC_EN,         // per tach input PWM sync
  output logic            O_PIN_EN,               // general purpose pins on
  output logic      [7:0] O_PIN_POLARITY,         // 1 active high per pin
  output logic      [7:0] O_PIN_DIRECTION,        // 1 output per pin, gated by enable
  output logic            O_SCL_TIMEOUT_EN,       // clock line timeout enable
  output logic            O_SDA_TIMEOUT_EN,       // data line timeout enable
  output logic            O_VID_LOW_THRESH,       // low VID input threshold
  output logic            O_THERM_LOW_THRESH,     // low THERM input threshold
  output logic            O_INTRUSION_LATCH_CLEAR,// one cycle clear pulse
  output logic            O_XOR_TREE_EN,          // XOR tree test mode
  output logic            O_CORE_LOW_EN,          // core rail low function
  output logic            O_LOCKED                // lock in force
);

  typedef struct packed {
    logic [7:0] cfg_two;
    logic [7:0] cfg_three;
    logic [7:0] tach_enable;
    logic [7:0] tach_config;
    logic [7:0] pin_config_one;
    logic [7:0] pin_config_two;
    logic       locked;
    logic [1:0] hot_one_sync;
    logic [1:0] hot_two_sync;
    logic [7:0] rdata;
    logic       full_speed;
    logic       meas_tick;
    logic [2:0] pulse_count;
    logic [7:0] meas_en;
    logic [7:0] stretch_en;
    logic [7:0] sync_en;
    logic [7:0] polarity;
    logic [7:0] direction;
    logic       intrusion_clear;
  } fmc_regs_s;

  fmc_regs_s r;
  fmc_regs_s next_r;

  fmc_rate_if rate ();

  fmc_rate_timer #(
    .SLOW_CYCLES (SLOW_CYCLES),
    .FAST_CYCLES (FAST_CYCLES)
  ) u_rate_timer (
    .i_clk  (I_MCLK),
    .i_nrst (I_NRST),
    .rate   (rate)
  );

  assign rate.fast     = r.cfg_two[CFG2_FAST_BIT];
  assign rate.low_freq = !r.cfg_two[CFG2_HIGH_FREQ_BIT];

  logic       wr_ok;
  logic       sw_rst;
  logic [7:0] new_cfg_two;
  logic [7:0] new_tach_config;
  logic [7:0] new_pin_cfg_one;
  logic [7:0] new_pin_cfg_two;
  logic [7:0] stretch_bits;
  logic [7:0] sync_bits;
  logic [7:0] pol_bits;
  logic [7:0] dir_bits;
  logic [15:0] pin_pair;

  // locked registers neither take writes nor a software reset
  // write blocking
  assign wr_ok  = I_WR && !r.locked && !I_SOFT_RESET;
  assign sw_rst = I_SOFT_RESET && !r.locked;

  // values that the per-bit decode sees in the next cycle
  assign new_cfg_two     = sw_rst ? RST_CFG_TWO :
                           (wr_ok && I_ADDR == ADDR_CFG_TWO) ? I_WDATA : r.cfg_two;
  assign new_tach_config = sw_rst ? RST_TACH_CONFIG :
                           (wr_ok && I_ADDR == ADDR_TACH_CONFIG) ?
                           (I_WDATA & TACH_CFG_WMASK) : r.tach_config;
  assign new_pin_cfg_one = sw_rst ? RST_PIN_CFG_ONE :
                           (wr_ok && I_ADDR == ADDR_PIN_CFG_ONE) ? I_WDATA : r.pin_config_one;
  assign new_pin_cfg_two = sw_rst ? RST_PIN_CFG_TWO :
                           (wr_ok && I_ADDR == ADDR_PIN_CFG_TWO) ? I_WDATA : r.pin_config_two;
  assign pin_pair        = {new_pin_cfg_two, new_pin_cfg_one};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TACH; gi++) begin : g_tach
      assign stretch_bits[gi] = !new_cfg_two[CFG2_HIGH_FREQ_BIT] &&
                                !new_tach_config[gi % NUM_PAIRS];
      assign sync_bits[gi]    = stretch_bits[gi];
      assign pol_bits[gi]     = pin_pair[2*gi];
      assign dir_bits[gi]     = pin_pair[2*gi+1];
    end
  endgenerate

  always_comb begin
    next_r = r;
    // synchronisers: first stage feeds only the second
    next_r.hot_one_sync = {r.hot_one_sync[0], I_REG_HOT_ONE};
    next_r.hot_two_sync = {r.hot_two_sync[0], I_REG_HOT_TWO};
    // lock holds until power-on reset
    if (I_LOCK) begin
      next_r.locked = 1'b1;
    end
    next_r.intrusion_clear = 1'b0;
    if (sw_rst) begin
      next_r.cfg_two        = RST_CFG_TWO;
      next_r.cfg_three      = RST_CFG_THREE;
      next_r.tach_enable    = RST_TACH_ENABLE;
      next_r.tach_config    = RST_TACH_CONFIG;
      next_r.pin_config_one = RST_PIN_CFG_ONE;
      next_r.pin_config_two = RST_PIN_CFG_TWO;
    end else if (wr_ok) begin
      case (I_ADDR)
        ADDR_CFG_TWO: begin
          next_r.cfg_two = I_WDATA;
        end
        ADDR_CFG_THREE: begin
          next_r.cfg_three       = I_WDATA & CFG3_WMASK;
          next_r.intrusion_clear = I_WDATA[CFG3_INTR_CLR_BIT];
        end
        ADDR_TACH_ENABLE: begin
          next_r.tach_enable = I_WDATA;
        end
        ADDR_TACH_CONFIG: begin
          next_r.tach_config = I_WDATA & TACH_CFG_WMASK;
        end
        ADDR_PIN_CFG_ONE: begin
          next_r.pin_config_one = I_WDATA;
        end
        ADDR_PIN_CFG_TWO: begin
          next_r.pin_config_two = I_WDATA;
        end
        default: begin
          next_r.cfg_two = r.cfg_two;
        end
      endcase
    end
    // read data stands only in the cycle after the strobe
    next_r.rdata = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        ADDR_CFG_TWO:     next_r.rdata = r.cfg_two;
        ADDR_CFG_THREE:   next_r.rdata = r.cfg_three & CFG3_WMASK;
        ADDR_TACH_ENABLE: next_r.rdata = r.tach_enable;
        ADDR_TACH_CONFIG: next_r.rdata = r.tach_config & TACH_CFG_WMASK;
        ADDR_PIN_CFG_ONE: next_r.rdata = r.pin_config_one;
        ADDR_PIN_CFG_TWO: next_r.rdata = r.pin_config_two;
        default:          next_r.rdata = RD_UNMAPPED;
      endcase
    end
    next_r.full_speed = new_cfg_two[CFG2_FULL_SPEED_BIT] ||
                        (r.hot_one_sync[1] && !new_cfg_two[CFG2_HOT_ONE_DIS_BIT]) ||
                        (r.hot_two_sync[1] && !new_cfg_two[CFG2_HOT_TWO_DIS_BIT]);
    next_r.meas_tick   = rate.tick;
    next_r.pulse_count = {1'b0, new_cfg_two[CFG2_PULSES_LSB +: 2]} + 3'h1;
    next_r.stretch_en  = stretch_bits;
    next_r.sync_en     = sync_bits;
    next_r.polarity    = pol_bits;
    next_r.direction   = dir_bits & {NUM_PINS{next_r.cfg_three[CFG3_PIN_EN_BIT]}};
    next_r.meas_en     = next_r.tach_enable;
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      r                <= '0;
      r.cfg_two        <= RST_CFG_TWO;
      r.cfg_three      <= RST_CFG_THREE;
      r.tach_enable    <= RST_TACH_ENABLE;
      r.tach_config    <= RST_TACH_CONFIG;
      r.pin_config_one <= RST_PIN_CFG_ONE;
      r.pin_config_two <= RST_PIN_CFG_TWO;
      r.pulse_count    <= 3'h3;
      r.stretch_en     <= 8'h00;
      r.sync_en        <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  assign O_RDATA                 = r.rdata;
  assign O_FULL_SPEED            = r.full_speed;
  assign O_HIGH_FREQ_PWM         = r.cfg_two[CFG2_HIGH_FREQ_BIT];
  assign O_FAST_RATE             = r.cfg_two[CFG2_FAST_BIT];
  assign O_SPEED_MEAS_TICK       = r.meas_tick;
  assign O_SPEED_PULSE_COUNT     = r.pulse_count;
  assign O_SPEED_MEAS_EN         = r.meas_en;
  assign O_CONTINUOUS_PAIR       = r.tach_config[NUM_PAIRS-1:0];
  assign O_PULSE_STRETCH_EN      = r.stretch_en;
  assign O_TACH_SYNC_EN          = r.sync_en;
  assign O_PIN_EN                = r.cfg_three[CFG3_PIN_EN_BIT];
  assign O_PIN_POLARITY          = r.polarity;
  assign O_PIN_DIRECTION         = r.direction;
  assign O_SCL_TIMEOUT_EN        = r.cfg_three[CFG3_SCL_TMO_BIT];
  assign O_SDA_TIMEOUT_EN        = r.cfg_three[CFG3_SDA_TMO_BIT];
  assign O_VID_LOW_THRESH        = r.cfg_three[CFG3_VID_THR_BIT];
  assign O_THERM_LOW_THRESH      = r.cfg_three[CFG3_THERM_THR_BIT];
  assign O_INTRUSION_LATCH_CLEAR = r.intrusion_clear;
  assign O_XOR_TREE_EN           = r.cfg_three[CFG3_XOR_TREE_BIT];
  assign O_CORE_LOW_EN           = r.cfg_three[CFG3_CORE_LOW_BIT];
  assign O_LOCKED                = r.locked;

  property p_force_full;
    @(posedge I_MCLK) disable iff (!I_NRST)
      r.cfg_two[CFG2_FULL_SPEED_BIT] |-> O_FULL_SPEED;
  endproperty
  a_force_full: assert property (p_force_full)
    else $error("forced full speed not shown");

  property p_hot_one;
    @(posedge I_MCLK) disable iff (!I_NRST)
      // a write or soft reset in this cycle may change the disable bit, so skip those
      (r.hot_one_sync[1] && !r.cfg_two[CFG2_HOT_ONE_DIS_BIT] &&
       !I_WR && !I_SOFT_RESET) |=> O_FULL_SPEED;
  endproperty
  a_hot_one: assert property (p_hot_one)
    else $error("first hot input did not boost fans");

  property p_hot_two_ignored;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (!r.hot_one_sync[1] && r.cfg_two[CFG2_HOT_TWO_DIS_BIT] &&
       !r.cfg_two[CFG2_FULL_SPEED_BIT] && !I_WR && !I_SOFT_RESET) |=> !O_FULL_SPEED;
  endproperty
  a_hot_two_ignored: assert property (p_hot_two_ignored)
    else $error("disabled second hot input changed fan speed");

  property p_locked_hold;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (r.locked && (I_WR || I_SOFT_RESET)) |=>
        $stable(r.cfg_two) && $stable(r.cfg_three) && $stable(r.tach_config);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("locked register changed");

  property p_soft_reset;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (I_SOFT_RESET && !r.locked) |=>
        r.cfg_two == RST_CFG_TWO && r.tach_config == RST_TACH_CONFIG &&
        r.pin_config_two == RST_PIN_CFG_TWO;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore defaults");

  property p_intrusion_pulse;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (wr_ok && I_ADDR == ADDR_CFG_THREE && I_WDATA[CFG3_INTR_CLR_BIT])
        |=> O_INTRUSION_LATCH_CLEAR ##1
          (!O_INTRUSION_LATCH_CLEAR || $past(wr_ok && I_ADDR == ADDR_CFG_THREE &&
                                             I_WDATA[CFG3_INTR_CLR_BIT]));
  endproperty
  a_intrusion_pulse: assert property (p_intrusion_pulse)
    else $error("intrusion clear pulse wrong");

  property p_clear_reads_zero;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (I_RD && I_ADDR == ADDR_CFG_THREE) |=> !O_RDATA[CFG3_INTR_CLR_BIT];
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero)
    else $error("intrusion clear bit read back set");

  property p_reserved_zero;
    @(posedge I_MCLK) disable iff (!I_NRST)
      (I_RD && I_ADDR == ADDR_TACH_CONFIG) |=> O_RDATA[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved tach config bits read set");

  property p_pulse_count;
    @(posedge I_MCLK) disable iff (!I_NRST)
      ##1 O_SPEED_PULSE_COUNT == {1'b0, r.cfg_two[CFG2_PULSES_LSB +: 2]} + 3'h1;
  endproperty
  a_pulse_count: assert property (p_pulse_count)
    else $error("pulse count decode wrong");

  property p_continuous_no_stretch;
    @(posedge I_MCLK) disable iff (!I_NRST)
      r.tach_config[0] |-> !O_PULSE_STRETCH_EN[0] && !O_TACH_SYNC_EN[4];
  endproperty
  a_continuous_no_stretch: assert property (p_continuous_no_stretch)
    else $error("continuous pair still stretched");

  property p_meas_enable;
    @(posedge I_MCLK) disable iff (!I_NRST)
      O_SPEED_MEAS_EN == r.tach_enable;
  endproperty
  a_meas_enable: assert property (p_meas_enable)
    else $error("measurement enables differ from register");

endmodule
`default_nettype wire

// *** fmc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fmc_host_model (
  input  wire logic       i_clk,   // bus clock
  input  wire logic [7:0] i_rdata, // read data from block
  output logic      [7:0] o_addr,  // register address
  output logic      [7:0] o_wdata, // write data
  output logic            o_wr,    // write strobe
  output logic            o_rd     // read strobe
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // idle lines show the inverse so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// *** fmc_config_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fmc_config_regs_tb;
  import fmc_pkg::*;
  localparam int SLOW = 40;
  localparam int FAST = 10;
  localparam logic [7:0] ADRS [7] = '{ADDR_CFG_TWO, ADDR_CFG_THREE, ADDR_TACH_ENABLE,
    ADDR_TACH_CONFIG, ADDR_PIN_CFG_ONE, ADDR_PIN_CFG_TWO, 8'h05};
  localparam logic [7:0] DEFS [7] = '{8'h80, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] FULL [7] = '{8'hFF, 8'hDF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h00};
  logic clk, nrst, lock, sreset, hot1, hot2;
  logic [7:0] addr, wdata, rdata, me, ps, ts, pp, pd;
  logic wr, rd, fs, hf, fr, tick, pe, st, sd, vt, tt, ic, xr, cl, lk;
  logic [2:0] pc;
  logic [3:0] cp;
  int num_errors = 0;
  int checks = 0;

  always #12.5 clk = ~clk;

  fmc_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));

  fmc_config_regs #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) u_dut (
    .I_MCLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_LOCK(lock), .I_SOFT_RESET(sreset), .I_REG_HOT_ONE(hot1),
    .I_REG_HOT_TWO(hot2), .O_FULL_SPEED(fs), .O_HIGH_FREQ_PWM(hf), .O_FAST_RATE(fr),
    .O_SPEED_MEAS_TICK(tick), .O_SPEED_PULSE_COUNT(pc), .O_SPEED_MEAS_EN(me),
    .O_CONTINUOUS_PAIR(cp), .O_PULSE_STRETCH_EN(ps), .O_TACH_SYNC_EN(ts), .O_PIN_EN(pe),
    .O_PIN_POLARITY(pp), .O_PIN_DIRECTION(pd), .O_SCL_TIMEOUT_EN(st), .O_SDA_TIMEOUT_EN(sd),
    .O_VID_LOW_THRESH(vt), .O_THERM_LOW_THRESH(tt), .O_INTRUSION_LATCH_CLEAR(ic),
    .O_XOR_TREE_EN(xr), .O_CORE_LOW_EN(cl), .O_LOCKED(lk));

  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask

  // bounded wait; returns cycles until the next tick
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 200);
    if (n >= 200) begin
      num_errors++;
      wrap_up();
    end
  endtask

  // one cycle of lock when sel is set, of soft reset otherwise
  task automatic pulse(input logic sel);
    @(posedge clk);
    lock   <= sel;
    sreset <= !sel;
    @(posedge clk);
    lock   <= 1'b0;
    sreset <= 1'b0;
    #1;
  endtask

  task automatic t_defaults();
    for (int i = 0; i < 7; i++) rchk(ADRS[i], DEFS[i]);
    chk("pulse count", {5'h0, pc}, 8'h03);
    chk("cont pair", {4'h0, cp}, 8'h0F);
  endtask

  task automatic t_all_ones();
    for (int i = 0; i < 6; i++) u_host.wr(ADRS[i], 8'hFF);
    for (int i = 0; i < 7; i++) rchk(ADRS[i], FULL[i]);
    chk("cfg2 outs", {1'b0, fs, hf, fr, 1'b0, pc}, 8'h74);
    chk("cfg3 outs", {1'b0, cl, xr, tt, vt, sd, st, pe}, 8'h7F);
    chk("meas en", me, 8'hFF);
    chk("pin dir", pd, 8'hFF);
    chk("stretch hf", ps, 8'h00);
  endtask

  task automatic t_intrusion();
    u_host.wr(ADDR_CFG_THREE, 8'h20);
    chk("intr clr", {7'h0, ic}, 8'h01);
    @(posedge clk);
    #1;
    chk("intr clr end", {7'h0, ic}, 8'h00);
    rchk(ADDR_CFG_THREE, 8'h00);
  endtask

  task automatic t_fields();
    for (int k = 0; k < 4; k++) begin
      u_host.wr(ADDR_CFG_TWO, {k[1:0], 6'h00});
      chk("pulse count", {5'h0, pc}, 8'(k + 1));
    end
    u_host.wr(ADDR_TACH_CONFIG, 8'h05);
    chk("stretch", ps, 8'hAA);
    chk("sync", ts, 8'hAA);
    u_host.wr(ADDR_PIN_CFG_ONE, 8'h55);
    u_host.wr(ADDR_PIN_CFG_TWO, 8'h55);
    u_host.wr(ADDR_CFG_THREE, 8'h01);
    chk("pol", pp, 8'hFF);
    chk("dir", pd, 8'h00);
    u_host.wr(ADDR_PIN_CFG_ONE, 8'hAA);
    u_host.wr(ADDR_PIN_CFG_TWO, 8'h00);
    chk("pol b", pp, 8'h00);
    chk("dir b", pd, 8'h0F);
    u_host.wr(ADDR_CFG_THREE, 8'h00);
    chk("dir off", pd, 8'h00);
  endtask

  task automatic t_hot();
    u_host.wr(ADDR_CFG_TWO, 8'h00);
    @(posedge clk);
    hot1 <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("hot one", {7'h0, fs}, 8'h01);
    u_host.wr(ADDR_CFG_TWO, 8'h08);
    chk("hot one off", {7'h0, fs}, 8'h00);
    @(posedge clk);
    hot1 <= 1'b0;
    hot2 <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("hot two", {7'h0, fs}, 8'h01);
    u_host.wr(ADDR_CFG_TWO, 8'h10);
    chk("hot two off", {7'h0, fs}, 8'h00);
    @(posedge clk);
    hot2 <= 1'b0;
  endtask

  task automatic t_rate();
    int n;
    u_host.wr(ADDR_CFG_TWO, 8'h00);
    wait_tick(n);
    wait_tick(n);
    chk("slow period", 8'(n), 8'(SLOW));
    u_host.wr(ADDR_CFG_TWO, 8'h01);
    wait_tick(n);
    wait_tick(n);
    wait_tick(n);
    chk("fast period", 8'(n), 8'(FAST));
    u_host.wr(ADDR_CFG_TWO, 8'h04);
    // a tick launched by the last low frequency reload may still be in flight
    repeat (2) @(posedge clk);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      n += int'(tick === 1'b1);
    end
    chk("hf ticks", 8'(n), 8'h00);
  endtask

  task automatic t_lock();
    u_host.wr(ADDR_TACH_ENABLE, 8'h3C);
    pulse(1'b0);
    rchk(ADDR_TACH_ENABLE, 8'h00);
    rchk(ADDR_CFG_TWO, 8'h80);
    u_host.wr(ADDR_TACH_ENABLE, 8'h3C);
    pulse(1'b1);
    chk("locked", {7'h0, lk}, 8'h01);
    u_host.wr(ADDR_TACH_ENABLE, 8'h11);
    rchk(ADDR_TACH_ENABLE, 8'h3C);
    pulse(1'b0);
    rchk(ADDR_TACH_ENABLE, 8'h3C);
  endtask

  // only a power-on reset lifts the lock
  task automatic t_power_cycle();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("lock cleared", {7'h0, lk}, 8'h00);
    rchk(ADDR_TACH_ENABLE, 8'h00);
    u_host.wr(ADDR_TACH_ENABLE, 8'h11);
    rchk(ADDR_TACH_ENABLE, 8'h11);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    lock = 1'b0;
    sreset = 1'b0;
    hot1 = 1'b0;
    hot2 = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_defaults();
    t_all_ones();
    t_intrusion();
    t_fields();
    t_hot();
    t_rate();
    t_lock();
    t_power_cycle();
    wrap_up();
  end
endmodule
`default_nettype wire
